/* logic/sac_pkg.sv */
// Package: register map, fields and timing for the SAR converter control
package sac_pkg;

	// ==========================================================
	// Register map (byte addresses; printed 0x1F is no multiple of 4)
	localparam logic [7:0]  CTRL_IDX     = 8'h1F;
	localparam logic [11:0] CTRL_ADDR    = {2'h0, CTRL_IDX, 2'h0};
	localparam logic [11:0] RESULT_ADDR  = 12'h000;
	localparam logic [11:0] PINCFG_ADDR  = 12'h004;
	localparam logic [11:0] IRQ_STAT_ADDR = 12'h008;
	localparam logic [11:0] IRQ_MASK_ADDR = 12'h00C;

	// ==========================================================
	// Control register fields
	localparam int CTRL_CS_HI  = 7;
	localparam int CTRL_CS_LO  = 6;
	localparam int CTRL_CH_HI  = 5;
	localparam int CTRL_CH_LO  = 3;
	localparam int CTRL_GO     = 2;
	localparam int CTRL_ON     = 0;
	localparam logic [7:0] CTRL_WMASK = 8'hFD;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Pin configuration register fields
	localparam int PINCFG_VREF = 7;
	localparam logic [7:0] PINCFG_RESET = 8'h00;

	// ==========================================================
	// Clock source encodings
	typedef enum logic [1:0] {
		SAC_CLK_DIV2  = 2'h0,
		SAC_CLK_DIV8  = 2'h1,
		SAC_CLK_DIV32 = 2'h2,
		SAC_CLK_RC    = 2'h3
	} sac_clksel_t;

	localparam logic [4:0] DIV2_TERM  = 5'h00;
	localparam logic [4:0] DIV8_TERM  = 5'h03;
	localparam logic [4:0] DIV32_TERM = 5'h0F;

	// Conversion length in half bit periods: 9.5 periods
	localparam logic [4:0] CONV_HALVES = 5'h13;
	localparam int         RESULT_W    = 8;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Analog front end request / reply
	typedef struct packed {
		logic                sample;
		logic [2:0]          channel;
		logic [RESULT_W-1:0] trial;
		logic                vref_ext;
		logic                power_on;
	} sac_afe_req_t;

endpackage

/* logic/sac_adc_ctrl.sv */
// SAR converter control: AXI4-Lite registers, clocking and sequencer
`timescale 1ns/1ps

//
// Overview of operation
// - Build 8-bit result by successive approximation
// - Pin config bit picks supply or external reference
// - Only RC clock keeps converting during sleep
// - Bits 7-6 pick clock /2, /8, /32, RC
// - Bits 5-3 pick one of eight inputs
// - Pin config register sets analog or digital pins
// - Result, control, pin config registers exposed
// - Reset clears control; bit 1 reads zero
// - Conversion lasts nine and a half bit periods
// - Go bit starts; hardware clears it when done
// - Power bit cleared shuts converter off
module sac_adc_ctrl
	import sac_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst_b,
	// AXI4-Lite write address / data / response
	input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// AXI4-Lite read address / data
	input  wire logic [ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// Device state and RC oscillator tick
	input  wire logic                 sleep_mode,
	input  wire logic                 rc_tick,
	// Analog front end
	output sac_afe_req_t              afe_req,
	input  wire logic                 comp_high,
	output logic [7:0]                analog_pin_cfg,
	// Interrupt
	output logic                      converter_irq
);

	typedef enum {SAC_IDLE, SAC_SAMPLE, SAC_BITS, SAC_TAIL} sac_state_t;

	// ==========================================================
	// Registers
	logic [7:0]          converter_control_r;
	logic [7:0]          pin_config_control_r;
	logic [RESULT_W-1:0] conversion_result_r;
	logic                stat_r;
	logic                mask_r;
	logic                done_r;
	sac_state_t          state_r;
	logic [4:0]          div_r;
	logic [4:0]          halves_r;
	logic [RESULT_W-1:0] sar_r;
	logic [2:0]          bit_r;
	logic                tick_half;

	// Bus handshake
	logic                aw_got_r;
	logic                w_got_r;
	logic [ADDR_W-1:0]   awaddr_r;
	logic [31:0]         wdata_r;
	logic [3:0]          wstrb_r;

	function automatic logic addr_known(input logic [ADDR_W-1:0] a);
		return a == ADDR_W'(CTRL_ADDR) || a == ADDR_W'(RESULT_ADDR) ||
			a == ADDR_W'(PINCFG_ADDR) || a == ADDR_W'(IRQ_STAT_ADDR) ||
			a == ADDR_W'(IRQ_MASK_ADDR);
	endfunction

	// Trial word at start: top bit set, the rest clear
	localparam logic [RESULT_W-1:0] SAR_FIRST = {1'b1, {(RESULT_W-1){1'b0}}};
	localparam logic [2:0]          BIT_TOP   = 3'(RESULT_W - 1);

	logic do_write;
	logic do_read;
	logic go_set;
	logic conv_on;
	logic wr_ctrl;
	logic rd_stat;
	assign do_write = aw_got_r && w_got_r && !s_axi_bvalid;
	assign do_read  = s_axi_arvalid && s_axi_arready;
	assign conv_on  = converter_control_r[CTRL_ON];
	// Decode shared by the start request and the control write
	assign wr_ctrl  = do_write && wstrb_r[0] &&
		awaddr_r == ADDR_W'(CTRL_ADDR);
	assign rd_stat  = do_read && s_axi_araddr == ADDR_W'(IRQ_STAT_ADDR);
	// Power must already be on: a go in the enabling write is refused
	assign go_set   = wr_ctrl && wdata_r[CTRL_GO] && conv_on;

	// ==========================================================
	// Write channel capture, either order
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			aw_got_r      <= 1'b0;
			w_got_r       <= 1'b0;
			awaddr_r      <= '0;
			wdata_r       <= 32'h0000_0000;
			wstrb_r       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_got_r && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !w_got_r && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= addr_known(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
				aw_got_r     <= 1'b0;
				w_got_r      <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Control and pin configuration registers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			converter_control_r  <= CTRL_RESET;
			pin_config_control_r <= PINCFG_RESET;
			mask_r               <= 1'b0;
		end else begin
			if (do_write && wstrb_r[0]) begin
				if (wr_ctrl) begin
					// Go stays hardware owned; only a start request may set it
					converter_control_r <= (wdata_r[7:0] & CTRL_WMASK &
						~(8'h01 << CTRL_GO)) |
						({7'h00, go_set} << CTRL_GO);
				end else if (awaddr_r == ADDR_W'(PINCFG_ADDR)) begin
					pin_config_control_r <= wdata_r[7:0];
				end else if (awaddr_r == ADDR_W'(IRQ_MASK_ADDR)) begin
					mask_r <= wdata_r[0];
				end
			end
			if (done_r && !go_set) begin
				converter_control_r[CTRL_GO] <= 1'b0;
			end
			if (!conv_on) begin
				converter_control_r[CTRL_GO] <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Read channel
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (do_read) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OKAY;
				s_axi_rdata  <= 32'h0000_0000;
				if (s_axi_araddr == ADDR_W'(CTRL_ADDR)) begin
					s_axi_rdata[7:0] <= converter_control_r;
				end else if (s_axi_araddr == ADDR_W'(RESULT_ADDR)) begin
					s_axi_rdata[7:0] <= conversion_result_r;
				end else if (s_axi_araddr == ADDR_W'(PINCFG_ADDR)) begin
					s_axi_rdata[7:0] <= pin_config_control_r;
				end else if (s_axi_araddr == ADDR_W'(IRQ_STAT_ADDR)) begin
					s_axi_rdata[0] <= stat_r;
				end else if (s_axi_araddr == ADDR_W'(IRQ_MASK_ADDR)) begin
					s_axi_rdata[0] <= mask_r;
				end else begin
					s_axi_rresp <= RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Half bit-period tick; divided sources halt in sleep
	logic [4:0] div_term;
	always_comb begin
		case (sac_clksel_t'(converter_control_r[CTRL_CS_HI:CTRL_CS_LO]))
			SAC_CLK_DIV2:  div_term = DIV2_TERM;
			SAC_CLK_DIV8:  div_term = DIV8_TERM;
			SAC_CLK_DIV32: div_term = DIV32_TERM;
			default:       div_term = DIV2_TERM;
		endcase
	end
	// RC tick passes straight through: the only source alive in sleep
	assign tick_half = (converter_control_r[CTRL_CS_HI:CTRL_CS_LO] ==
		SAC_CLK_RC) ? rc_tick :
		(!sleep_mode && div_r == div_term);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			div_r <= 5'h00;
		end else if (state_r == SAC_IDLE || tick_half || sleep_mode) begin
			div_r <= 5'h00;
		end else begin
			div_r <= div_r + 5'h01;
		end
	end

	// ==========================================================
	// Successive approximation sequencer
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_r  <= SAC_IDLE;
			halves_r <= 5'h00;
			sar_r    <= 8'h00;
			bit_r    <= 3'h0;
			done_r   <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (!conv_on) begin
				state_r <= SAC_IDLE;
			end else begin
				case (state_r)
					SAC_IDLE: begin
						if (go_set) begin
							state_r  <= SAC_SAMPLE;
							halves_r <= 5'h00;
							sar_r    <= SAR_FIRST;
							bit_r    <= BIT_TOP;
						end
					end
					SAC_SAMPLE: begin
						if (tick_half) begin
							halves_r <= halves_r + 5'h01;
							state_r  <= SAC_BITS;
						end
					end
					SAC_BITS: begin
						if (tick_half) begin
							halves_r <= halves_r + 5'h01;
							// Decide at the end of each full period
							if (!halves_r[0]) begin
								if (!comp_high) begin
									sar_r[bit_r] <= 1'b0;
								end
								if (bit_r == 3'h0) begin
									state_r <= SAC_TAIL;
								end else begin
									sar_r[bit_r - 3'h1] <= 1'b1;
									bit_r <= bit_r - 3'h1;
								end
							end
						end
					end
					SAC_TAIL: begin
						if (tick_half) begin
							halves_r <= halves_r + 5'h01;
							if (halves_r == CONV_HALVES - 5'h01) begin
								state_r <= SAC_IDLE;
								done_r  <= 1'b1;
							end
						end
					end
					default: state_r <= SAC_IDLE;
				endcase
			end
		end
	end

	// ==========================================================
	// Result register
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			conversion_result_r <= 8'h00;
		end else if (done_r) begin
			conversion_result_r <= sar_r;
		end
	end

	// A completion in the clearing read cycle still sets the flag
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			stat_r <= 1'b0;
		end else if (done_r) begin
			stat_r <= 1'b1;
		end else if (rd_stat) begin
			stat_r <= 1'b0;
		end
	end

	// Done folded in so the line rises with the status bit
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			converter_irq <= 1'b0;
		end else begin
			converter_irq <= (stat_r || done_r) && mask_r;
		end
	end

	// ==========================================================
	// Front end request and pin configuration
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			afe_req <= '0;
		end else begin
			// Sampling stops in the same cycle as the power bit
			afe_req.sample   <= state_r == SAC_SAMPLE && conv_on;
			afe_req.channel  <=
				converter_control_r[CTRL_CH_HI:CTRL_CH_LO];
			afe_req.trial    <= sar_r;
			afe_req.vref_ext <= pin_config_control_r[PINCFG_VREF];
			afe_req.power_on <= conv_on;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			analog_pin_cfg <= 8'h00;
		end else begin
			analog_pin_cfg <= pin_config_control_r;
		end
	end

endmodule

/* testbench/sac_afe_model.sv */
// Analog front end model: channel levels, hold capacitor, comparator
`timescale 1ns/1ps
module sac_afe_model
	import sac_pkg::*;
#(
	parameter logic [63:0] LVL = 64'h0
) (
	// Clock and request
	input  wire logic         clock,
	input  wire sac_afe_req_t afe_req,
	// Comparator
	output logic              comp_high
);
	logic [7:0] held_r = 8'h00;
	logic       last_r = 1'h0;
	// Hold capacitor tracks the channel only while sampling
	always @(posedge clock) begin
		if (afe_req.sample) begin
			held_r <= LVL[afe_req.channel*8+:8];
		end
		last_r <= comp_high;
	end
	// Unpowered comparator means nothing: toggle so no value passes by luck
	assign comp_high = afe_req.power_on ?
		(held_r >= afe_req.trial) : ~last_r;
endmodule

/* testbench/sac_adc_ctrl_chk.sv */
// Checker: bus handshakes and front end requests
`timescale 1ns/1ps
module sac_adc_ctrl_chk
	import sac_pkg::*;
(
	// Clock, reset, bus
	input wire logic        clock, rst_b,
	input wire logic        s_axi_awvalid, s_axi_awready,
	input wire logic        s_axi_wvalid, s_axi_wready,
	input wire logic        s_axi_bvalid, s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid, s_axi_arready,
	input wire logic        s_axi_rvalid, s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Front end
	input wire sac_afe_req_t afe_req,
	input wire logic [7:0]  analog_pin_cfg
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	// ==========================================================
	// Bus
	a_bresp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_rdata_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write answer late");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_upper_zero: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	// ==========================================================
	// Front end
	a_vref_follow: assert property (
		afe_req.vref_ext == analog_pin_cfg[PINCFG_VREF])
		else $error("reference select mismatch");
	a_msb_first: assert property (
		$fell(afe_req.sample) && afe_req.power_on
		|-> ##[0:1] afe_req.trial == 8'h80) else $error("first trial not MSB");
	a_sample_power: assert property (
		afe_req.sample |-> afe_req.power_on) else $error("sampling while off");
endmodule
bind sac_adc_ctrl sac_adc_ctrl_chk u_sac_adc_ctrl_chk (.clock, .rst_b,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.afe_req, .analog_pin_cfg);

/* testbench/sac_adc_ctrl_tb_top.sv */
// Testbench: registers, conversions on every clock, sleep, abort
`timescale 1ns/1ps
module sac_adc_ctrl_tb_top;
	import sac_pkg::*;
	localparam logic [63:0] LVL = 64'hF1A65B00FF807F01;
	logic         clock = 1'h0, rst_b = 1'h0;
	logic [11:0]  s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]   s_axi_wstrb = 4'hF;
	logic         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic         s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic         s_axi_rready = 1'h0, sleep_mode = 1'h0, rc_tick = 1'h0;
	logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic         s_axi_rvalid, converter_irq, comp_high;
	logic [1:0]   s_axi_bresp, s_axi_rresp, r;
	logic [7:0]   analog_pin_cfg;
	logic [2:0]   rc_cnt = 3'h0;
	logic [31:0]  d;
	sac_afe_req_t afe_req;
	int           errors = 0, n_tests = 0;
	sac_adc_ctrl u_sac_adc_ctrl (.clock, .rst_b, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.sleep_mode, .rc_tick, .afe_req, .comp_high, .analog_pin_cfg,
		.converter_irq);
	sac_afe_model #(.LVL(LVL)) u_sac_afe_model (.clock, .afe_req, .comp_high);
	// ==========================================================
	// Clocks: RC half period is five system cycles
	always #2 clock = ~clock;
	always @(posedge clock) begin
		rc_cnt <= (rc_cnt == 3'h4) ? 3'h0 : rc_cnt + 3'h1;
		rc_tick <= (rc_cnt == 3'h4);
	end
	// ==========================================================
	// Bus and check tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		logic ad, dd;
		ad = 1'h0;
		dd = 1'h0;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!(ad && dd)) begin
			@(posedge clock);
			if (s_axi_awready && !ad) begin
				ad = 1'h1;
				s_axi_awvalid <= 1'h0;
			end
			if (s_axi_wready && !dd) begin
				dd = 1'h1;
				s_axi_wvalid <= 1'h0;
			end
		end
		do @(posedge clock); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge clock); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge clock); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_regs;
		rd(CTRL_ADDR); chk(d, 32'h0);
		rd(PINCFG_ADDR); chk(d, 32'h0);
		wr(CTRL_ADDR, 8'hFE); rd(CTRL_ADDR); chk(d, 32'hF8);
		wr(CTRL_ADDR, 8'h00);
		wr(PINCFG_ADDR, 8'h8F); rd(PINCFG_ADDR); chk(d, 32'h8F);
		chk(analog_pin_cfg, 32'h8F);
		chk(afe_req.vref_ext, 32'h1);
		wr(PINCFG_ADDR, 8'h00);
		s_axi_wstrb <= 4'hE;
		wr(PINCFG_ADDR, 8'h33); chk(r, RESP_OKAY);
		rd(PINCFG_ADDR); chk(d, 32'h0);
		s_axi_wstrb <= 4'hF;
		wr(12'h010, 8'h55); chk(r, RESP_SLVERR);
		rd(12'h010); chk(r, RESP_SLVERR); chk(d, 32'h0);
		wr(IRQ_MASK_ADDR, 8'h01); rd(IRQ_MASK_ADDR); chk(d, 32'h1);
		$display("t_regs done");
	endtask
	task automatic conv(input logic [1:0] cs, input logic [2:0] ch);
		int n, h;
		h = (cs == 2'h0) ? 1 : (cs == 2'h1) ? 4 : (cs == 2'h2) ? 16 : 5;
		n = 0;
		sleep_mode <= (cs == 2'h3); // RC must keep going asleep
		wr(CTRL_ADDR, {cs, ch, 3'h1});
		wr(CTRL_ADDR, {cs, ch, 3'h5});
		while (converter_irq !== 1'b1) begin
			@(posedge clock);
			n++;
		end
		// RC ticks run free, so the first half period is 1 to 5 cycles
		chk(cs == 2'h3 ? (n >= 19 * h - 3 && n <= 19 * h + 1) :
			(n == 19 * h + 1), 32'h1);
		sleep_mode <= 1'h0;
		rd(CTRL_ADDR); chk(d, {cs, ch, 3'h1});
		rd(RESULT_ADDR); chk(d, LVL[ch*8+:8]);
		rd(IRQ_STAT_ADDR); chk(d, 32'h1);
		rd(IRQ_STAT_ADDR); chk(d, 32'h0);
		chk(converter_irq, 32'h0);
		repeat (4 * h) @(posedge clock);
		$display("conv done ch %0d", ch);
	endtask
	task automatic t_abort;
		wr(CTRL_ADDR, 8'hA1);
		wr(CTRL_ADDR, 8'hA5);
		repeat (20) @(posedge clock);
		wr(CTRL_ADDR, 8'hA0); rd(CTRL_ADDR); chk(d, 32'hA0);
		repeat (400) @(posedge clock);
		chk(converter_irq, 32'h0);
		rd(IRQ_STAT_ADDR); chk(d, 32'h0);
		$display("t_abort done");
	endtask
	task automatic t_sleep;
		wr(IRQ_MASK_ADDR, 8'h00);
		sleep_mode <= 1'h1;
		wr(CTRL_ADDR, 8'h11);
		wr(CTRL_ADDR, 8'h15);
		repeat (60) @(posedge clock);
		rd(CTRL_ADDR); chk(d, 32'h15);
		sleep_mode <= 1'h0;
		repeat (60) @(posedge clock);
		chk(converter_irq, 32'h0);
		rd(IRQ_STAT_ADDR); chk(d, 32'h1);
		rd(RESULT_ADDR); chk(d, LVL[23:16]);
		wr(IRQ_MASK_ADDR, 8'h01);
		$display("t_sleep done");
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (3) @(posedge clock);
		rst_b <= 1'h1;
		t_regs;
		for (int c = 0; c < 8; c++) begin
			conv(c[1:0], c[2:0]);
		end
		t_abort;
		t_sleep;
		final_report;
	end
	initial begin
		#80000;
		errors++;
		final_report;
	end
endmodule
